// *** verilog/tmc_regs.vh ***
`ifndef TMC_REGS_VH
`define TMC_REGS_VH

// ***************************************************************
// register map (byte addresses)
// ***************************************************************
`define ADDR_CTRL      8'h00
`define ADDR_CMD       8'h04
`define ADDR_STATUS    8'h08
`define ADDR_IRQ_STAT  8'h0c
`define ADDR_IRQ_MASK  8'h10
`define ADDR_CAL       8'h14
`define ADDR_RES_SEL   8'h18
`define ADDR_RES_DATA  8'h1c
`define ADDR_OFFSET    8'h20

// ***************************************************************
// field positions and reset values
// ***************************************************************
`define CTRL_MULTI     0
`define CTRL_JMM       1
`define CTRL_RST       2'h0
`define CMD_INIT       0
`define CMD_LAUNCH     1
`define CAL_RST        8'h40
`define IRQ_TABLE      0
`define IRQ_TUNED      1
`define IRQ_SCAN       2
`define IRQ_RESULT     3
`define IRQ_W          4

// ***************************************************************
// sizes
// ***************************************************************
`define DW             17
`define CW             16
`define NSENS          3'h4
`define NFREQ          2'h3
`define NCH            12
`define TBL_N          16
`define MA_SHIFT       3

// ***************************************************************
// tuning and multi-clock constants
// ***************************************************************
`define TUNE_TARGET    16'h0400
`define RATIO_F0       8'h10
`define RATIO_F1       8'h12
`define RATIO_F2       8'h14
`define RATIO_SH       4

// ***************************************************************
// sequencer states
// ***************************************************************
`define ST_IDLE        3'h0
`define ST_INIT        3'h1
`define ST_TUNE        3'h2
`define ST_READY       3'h3
`define ST_SCAN        3'h4
`define ST_DRAIN       3'h5
`define ST_PROC        3'h6

`endif

// *** verilog/cco_table.v ***
`timescale 1ns/1ps
`include "tmc_regs.vh"

module cco_table (
  // clock and reset
  input wire clk_in,
  input wire resetn_in,
  // table build
  input wire build_in,
  input wire [7:0] cal_in,
  output reg ready_out,
  // sample path
  input wire valid_in,
  input wire [`CW-1:0] count_in,
  output reg valid_out,
  output reg [`CW-1:0] corr_out
);

  reg [`CW-1:0] entry_q [0:`TBL_N-1];
  reg [4:0] idx_q;
  reg busy_q;
  wire [3:0] i4 = idx_q[3:0];
  wire [3:0] inv4 = 4'hf - i4;
  wire [15:0] bow = ({8'h00, i4} * {8'h00, inv4}) * {8'h00, cal_in};
  integer k;

  // builds one entry per clock; the bow term undoes the oscillator's sagging slope
  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      idx_q <= 5'h00;
      busy_q <= 1'b0;
      ready_out <= 1'b0;
      for (k = 0; k < `TBL_N; k = k + 1) begin
        entry_q[k] <= 16'h0000;
      end
    end else if (build_in) begin
      idx_q <= 5'h00;
      busy_q <= 1'b1;
      ready_out <= 1'b0;
    end else if (busy_q) begin
      entry_q[i4] <= {i4, 12'h000} + {2'b00, bow[15:2]};
      idx_q <= idx_q + 5'h01;
      if (i4 == 4'hf) begin
        busy_q <= 1'b0;
        ready_out <= 1'b1;
      end
    end
  end

  // linear within a segment, table sets the segment base
  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      valid_out <= 1'b0;
      corr_out <= 16'h0000;
    end else begin
      valid_out <= valid_in;
      corr_out <= entry_q[count_in[15:12]] + {4'h0, count_in[11:0]};
    end
  end

endmodule

// *** verilog/ma_bank.v ***
`timescale 1ns/1ps
`include "tmc_regs.vh"

module ma_bank (
  // clock and reset
  input wire clk_in,
  input wire resetn_in,
  // update port
  input wire clear_in,
  input wire upd_in,
  input wire [3:0] idx_in,
  input wire [`DW-1:0] x_in,
  // read port
  input wire [3:0] rd_idx_in,
  output wire [`DW-1:0] avg_out
);

  wire [`DW-1:0] acc_w [0:`NCH-1];
  genvar g;

  // one accumulator per sensor and frequency channel
  generate
    for (g = 0; g < `NCH; g = g + 1) begin : chan
      reg [`DW-1:0] acc_q;
      reg seeded_q;
      wire signed [`DW+1:0] diff = $signed({2'b00, x_in}) - $signed({2'b00, acc_q});
      wire signed [`DW+1:0] step = diff >>> `MA_SHIFT;
      wire [`DW+1:0] nxt = {2'b00, acc_q} + step;
      assign acc_w[g] = acc_q;
      // first sample seeds the average so it does not ramp from zero
      always @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
          acc_q <= 17'h00000;
          seeded_q <= 1'b0;
        end else if (clear_in) begin
          acc_q <= 17'h00000;
          seeded_q <= 1'b0;
        end else if (upd_in && idx_in == g) begin
          seeded_q <= 1'b1;
          acc_q <= seeded_q ? nxt[`DW-1:0] : x_in;
        end
      end
    end
  endgenerate

  assign avg_out = (rd_idx_in < `NCH) ? acc_w[rd_idx_in] : 17'h00000;

endmodule

// *** verilog/touch_measurement_correction.v ***
// The implementer's own choices: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`include "tmc_regs.vh"

// Function
// [RULE1] sequence runs setup, then offset tuning, then detection scans
// [RULE2] software repeats launch, fetch results, wait; wait sets cycle period
// [RULE3] completion from measurement unit flags scan finished and starts processing
// [RULE4] correction table is built during setup before any value is corrected
// [RULE5] each acquired value gets offset removal and correction before judgement
// [RULE6] single-frequency: one random-pulse result, correction then moving average
// [RULE7] value-majority measures each sensor at three frequencies, high-resolution pulses
// [RULE8] correction applied to every count of every drive frequency
// [RULE9] value-majority rescales per-frequency values to one common frequency basis
// [RULE10] two closest of three rescaled values are summed into one
// [RULE11] value-majority merged value is averaged, one result per sensor
// [RULE12] judgement-majority measures each sensor at three frequencies, high-resolution pulses
// [RULE13] judgement-majority skips merging, averages each value, three results per sensor
// [RULE14] table maps raw counts so output is linear in oscillator current
// [RULE15] moving average smooths successive values of each sensor
// [RULE16] fixed averaging window, separate accumulator per sensor and frequency
// [RULE17] results valid only after every sensor and frequency is processed
module touch_measurement_correction (
  // clock and reset
  input wire clk_in,
  input wire resetn_in,
  // register port
  input wire [7:0] addr_in,
  input wire [31:0] wdata_in,
  input wire wr_in,
  input wire rd_in,
  output reg [31:0] rdata_out,
  // measurement unit
  output reg scan_launch_out,
  output wire high_res_out,
  output wire [1:0] freq_count_out,
  input wire meas_valid_in,
  input wire [`CW-1:0] meas_count_in,
  input wire [1:0] meas_sensor_in,
  input wire [1:0] meas_freq_in,
  input wire meas_done_in,
  // judgement side
  output reg result_valid_out,
  output reg judge_ready_out,
  output wire irq_out
);

  // ***************************************************************
  // declarations
  // ***************************************************************
  reg [1:0] ctrl_q;
  reg [7:0] cal_q;
  reg [3:0] res_sel_q;
  reg [`IRQ_W-1:0] irq_stat_q;
  reg [`IRQ_W-1:0] irq_mask_q;
  reg [2:0] state_q;
  reg tuning_q;
  reg build_q;
  reg ma_clear_q;
  reg [1:0] sens_q;
  reg [1:0] fq_q;
  reg [1:0] smp_sens_q;
  reg [1:0] smp_freq_q;
  reg [`CW-1:0] off_q [0:`NCH-1];
  reg [`CW-1:0] val_q [0:`NCH-1];
  reg [`IRQ_W-1:0] irq_set;
  reg ma_upd;
  reg [`DW-1:0] ma_x;
  wire tbl_ready;
  wire corr_valid;
  wire [`CW-1:0] corr;
  wire [`DW-1:0] avg;
  wire [3:0] smp_ch;
  wire [3:0] proc_ch;
  wire [3:0] base_ch;
  wire multi;
  wire judgement_majority_mode;
  wire wr_cmd;
  integer k;

  // channel number from sensor and frequency
  function [3:0] chan;
    input [1:0] s;
    input [1:0] f;
    begin
      chan = {s, 1'b0} + {2'b00, s} + {2'b00, f};
    end
  endfunction

  // distance between two rescaled values
  function [`DW-1:0] absdiff;
    input [`DW-1:0] a;
    input [`DW-1:0] b;
    begin
      absdiff = (a > b) ? a - b : b - a;
    end
  endfunction

  // rescale to the common basis of the first drive frequency
  function [`DW-1:0] rescale;
    input [`CW-1:0] v;
    input [7:0] r;
    reg [`CW+7:0] p;
    begin
      p = {8'h00, v} * {16'h0000, r};
      rescale = p[`DW+`RATIO_SH-1:`RATIO_SH];
    end
  endfunction

  assign multi = ctrl_q[`CTRL_MULTI];
  assign judgement_majority_mode = ctrl_q[`CTRL_JMM];
  assign wr_cmd = wr_in && addr_in == `ADDR_CMD;
  assign smp_ch = chan(smp_sens_q, smp_freq_q);
  assign proc_ch = chan(sens_q, fq_q);
  assign base_ch = chan(sens_q, 2'h0);

  // [RULE6] random pulses, one frequency
  // [RULE7] [RULE12] three frequencies, high resolution
  assign high_res_out = multi;
  assign freq_count_out = multi ? `NFREQ : 2'h1;

  // ***************************************************************
  // correction and averaging stages
  // ***************************************************************
  // [RULE14] [RULE8] every count through the table
  cco_table u_cco (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .build_in(build_q),
    .cal_in(cal_q),
    .ready_out(tbl_ready),
    .valid_in(meas_valid_in),
    .count_in(meas_count_in),
    .valid_out(corr_valid),
    .corr_out(corr)
  );

  // [RULE15] [RULE16] per channel smoothing
  ma_bank u_ma (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .clear_in(ma_clear_q),
    .upd_in(ma_upd),
    .idx_in(proc_ch),
    .x_in(ma_x),
    .rd_idx_in(res_sel_q),
    .avg_out(avg)
  );

  // ***************************************************************
  // multi-clock merge and average feed
  // ***************************************************************
  reg [`DW-1:0] r0;
  reg [`DW-1:0] r1;
  reg [`DW-1:0] r2;
  reg [`DW-1:0] d01;
  reg [`DW-1:0] d12;
  reg [`DW-1:0] d02;
  reg [`DW-1:0] merged;
  always @* begin
    // [RULE9] common frequency basis
    r0 = rescale(val_q[base_ch], `RATIO_F0);
    r1 = rescale(val_q[base_ch + 4'h1], `RATIO_F1);
    r2 = rescale(val_q[base_ch + 4'h2], `RATIO_F2);
    d01 = absdiff(r0, r1);
    d12 = absdiff(r1, r2);
    d02 = absdiff(r0, r2);
    // [RULE10] closest pair summed; ties go to r0+r1 first, then r1+r2 before r0+r2
    if (d01 <= d12 && d01 <= d02) begin
      merged = r0 + r1;
    end else if (d12 <= d02) begin
      merged = r1 + r2;
    end else begin
      merged = r0 + r2;
    end
    ma_upd = 1'b0;
    ma_x = {1'b0, val_q[proc_ch]};
    if (state_q == `ST_PROC) begin
      if (multi && judgement_majority_mode) begin
        // [RULE13] each frequency averaged on its own
        ma_upd = 1'b1;
      end else if (fq_q == 2'h0) begin
        // [RULE11] merged value into one average
        ma_upd = 1'b1;
        if (multi) begin
          ma_x = merged;
        end
      end
    end
  end

  // ***************************************************************
  // sequencer
  // ***************************************************************
  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_q <= `ST_IDLE;
      tuning_q <= 1'b0;
      build_q <= 1'b0;
      ma_clear_q <= 1'b0;
      scan_launch_out <= 1'b0;
      result_valid_out <= 1'b0;
      judge_ready_out <= 1'b0;
      sens_q <= 2'h0;
      fq_q <= 2'h0;
    end else begin
      build_q <= 1'b0;
      ma_clear_q <= 1'b0;
      scan_launch_out <= 1'b0;
      judge_ready_out <= 1'b0;
      case (state_q)
        `ST_IDLE: begin
          // [RULE4] table first, averages cleared
          if (wr_cmd && wdata_in[`CMD_INIT]) begin
            build_q <= 1'b1;
            ma_clear_q <= 1'b1;
            result_valid_out <= 1'b0;
            state_q <= `ST_INIT;
          end
        end
        `ST_INIT: begin
          // [RULE1] tuning scan follows setup
          if (tbl_ready && !build_q) begin
            tuning_q <= 1'b1;
            scan_launch_out <= 1'b1;
            state_q <= `ST_SCAN;
          end
        end
        `ST_READY: begin
          // [RULE2] software paces the scans
          // [RULE4] re-init rebuilds the table and retunes; a detour through idle would need a second write
          if (wr_cmd && wdata_in[`CMD_INIT]) begin
            build_q <= 1'b1;
            ma_clear_q <= 1'b1;
            result_valid_out <= 1'b0;
            state_q <= `ST_INIT;
          end else if (wr_cmd && wdata_in[`CMD_LAUNCH]) begin
            result_valid_out <= 1'b0;
            scan_launch_out <= 1'b1;
            state_q <= `ST_SCAN;
          end
        end
        `ST_SCAN: begin
          // [RULE3] completion ends the scan
          if (meas_done_in) begin
            state_q <= `ST_DRAIN;
          end
        end
        `ST_DRAIN: begin
          // last corrected sample lands this cycle
          sens_q <= 2'h0;
          fq_q <= 2'h0;
          tuning_q <= 1'b0;
          state_q <= tuning_q ? `ST_READY : `ST_PROC;
        end
        `ST_PROC: begin
          // [RULE17] valid only after the last channel
          if (fq_q == `NFREQ - 2'h1) begin
            fq_q <= 2'h0;
            if ({1'b0, sens_q} == `NSENS - 3'h1) begin
              result_valid_out <= 1'b1;
              judge_ready_out <= 1'b1;
              state_q <= `ST_READY;
            end else begin
              sens_q <= sens_q + 2'h1;
            end
          end else begin
            fq_q <= fq_q + 2'h1;
          end
        end
        default: begin
          state_q <= `ST_IDLE;
        end
      endcase
    end
  end

  // ***************************************************************
  // sample capture: offsets during tuning, values afterwards
  // ***************************************************************
  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      smp_sens_q <= 2'h0;
      smp_freq_q <= 2'h0;
      for (k = 0; k < `NCH; k = k + 1) begin
        off_q[k] <= 16'h0000;
        val_q[k] <= 16'h0000;
      end
    end else begin
      smp_sens_q <= meas_sensor_in;
      smp_freq_q <= meas_freq_in;
      // out-of-range frequency tags are dropped, not aliased
      if (corr_valid && smp_freq_q != 2'h3 && (state_q == `ST_SCAN || state_q == `ST_DRAIN)) begin
        if (tuning_q) begin
          off_q[smp_ch] <= (corr > `TUNE_TARGET) ? corr - `TUNE_TARGET : 16'h0000;
        end else begin
          // [RULE5] offset removed after correction
          val_q[smp_ch] <= (corr > off_q[smp_ch]) ? corr - off_q[smp_ch] : 16'h0000;
        end
      end
    end
  end

  // ***************************************************************
  // register writes and interrupt status
  // ***************************************************************
  always @* begin
    irq_set = 4'h0;
    irq_set[`IRQ_TABLE] = state_q == `ST_INIT && tbl_ready && !build_q;
    irq_set[`IRQ_TUNED] = state_q == `ST_DRAIN && tuning_q;
    irq_set[`IRQ_SCAN] = state_q == `ST_SCAN && meas_done_in;
    irq_set[`IRQ_RESULT] = judge_ready_out;
  end

  // set wins over a same-cycle write-one clear
  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ctrl_q <= `CTRL_RST;
      cal_q <= `CAL_RST;
      res_sel_q <= 4'h0;
      irq_mask_q <= 4'h0;
      irq_stat_q <= 4'h0;
    end else begin
      // mode bits only take effect between scans to keep a scan consistent
      if (wr_in && addr_in == `ADDR_CTRL && (state_q == `ST_IDLE || state_q == `ST_READY)) begin
        ctrl_q <= wdata_in[1:0];
      end
      if (wr_in && addr_in == `ADDR_CAL && state_q == `ST_IDLE) begin
        cal_q <= wdata_in[7:0];
      end
      if (wr_in && addr_in == `ADDR_RES_SEL) begin
        res_sel_q <= wdata_in[3:0];
      end
      if (wr_in && addr_in == `ADDR_IRQ_MASK) begin
        irq_mask_q <= wdata_in[`IRQ_W-1:0];
      end
      if (wr_in && addr_in == `ADDR_IRQ_STAT) begin
        irq_stat_q <= (irq_stat_q & ~wdata_in[`IRQ_W-1:0]) | irq_set;
      end else begin
        irq_stat_q <= irq_stat_q | irq_set;
      end
    end
  end

  assign irq_out = |(irq_stat_q & irq_mask_q);

  // ***************************************************************
  // register reads, data one cycle after the strobe
  // ***************************************************************
  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rdata_out <= 32'h00000000;
    end else if (rd_in) begin
      case (addr_in)
        `ADDR_CTRL: rdata_out <= {30'h00000000, ctrl_q};
        `ADDR_STATUS: rdata_out <= {27'h0000000, tbl_ready, result_valid_out, state_q};
        `ADDR_IRQ_STAT: rdata_out <= {28'h0000000, irq_stat_q};
        `ADDR_IRQ_MASK: rdata_out <= {28'h0000000, irq_mask_q};
        `ADDR_CAL: rdata_out <= {24'h000000, cal_q};
        `ADDR_RES_SEL: rdata_out <= {28'h0000000, res_sel_q};
        `ADDR_RES_DATA: rdata_out <= {15'h0000, avg};
        `ADDR_OFFSET: rdata_out <= (res_sel_q < `NCH) ? {16'h0000, off_q[res_sel_q]} : 32'h00000000;
        default: rdata_out <= 32'h00000000;
      endcase
    end else begin
      rdata_out <= 32'h00000000;
    end
  end

endmodule

// *** verif/touch_measurement_correction_monitor.sv ***
`timescale 1ns/1ps
`include "tmc_regs.vh"

module touch_measurement_correction_monitor (
  // clock and reset
  input wire clk_in,
  input wire resetn_in,
  // register port
  input wire [7:0] addr_in,
  input wire [31:0] wdata_in,
  input wire wr_in,
  input wire rd_in,
  input wire [31:0] rdata_out,
  // measurement and judgement side
  input wire scan_launch_out,
  input wire high_res_out,
  input wire [1:0] freq_count_out,
  input wire meas_done_in,
  input wire result_valid_out,
  input wire judge_ready_out,
  input wire irq_out
);
  reg user_q;
  reg mask_q;
  wire cmd_wr;

  // tuning scans give no results, so only user launches arm the timing checks
  assign cmd_wr = wr_in && addr_in == `ADDR_CMD;
  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      user_q <= 1'h0;
      mask_q <= 1'h0;
    end else begin
      if (cmd_wr)
        user_q <= wdata_in[`CMD_LAUNCH];
      if (wr_in && addr_in == `ADDR_IRQ_MASK)
        mask_q <= wdata_in[`IRQ_RESULT];
    end
  end

  // ********
  // assertions
  // ********
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!resetn_in);

  a_rdata_idle:
    assert property (!rd_in |=> rdata_out == 32'h0) else $error("stray read data");
  a_launch_pulse:
    assert property (scan_launch_out |=> !scan_launch_out) else $error("long launch");
  a_launch_on_cmd:
    assert property (cmd_wr && wdata_in[1:0] == 2'h2 && result_valid_out |=> scan_launch_out)
      else $error("launch missing");
  a_launch_clears:
    assert property (scan_launch_out |=> !result_valid_out) else $error("stale results");
  a_done_to_ready:
    assert property (meas_done_in && user_q |-> ##14 judge_ready_out) else $error("ready mistimed");
  a_no_early_valid:
    assert property (meas_done_in && user_q |-> !result_valid_out [*8]) else $error("early results");
  a_ready_on_rise:
    assert property (judge_ready_out |-> $rose(result_valid_out)) else $error("ready without results");
  a_rise_gives_ready:
    assert property ($rose(result_valid_out) |-> judge_ready_out) else $error("results without ready");
  a_valid_holds:
    assert property (result_valid_out && !wr_in && !$past(wr_in) |=> result_valid_out)
      else $error("results dropped");
  a_mode_count:
    assert property (freq_count_out == (high_res_out ? 2'h3 : 2'h1)) else $error("bad count");
  a_irq_result:
    assert property (judge_ready_out && mask_q |=> irq_out) else $error("irq missing");

  c_multi: cover property (judge_ready_out && high_res_out);
  c_single: cover property (judge_ready_out && !high_res_out);
  c_irq: cover property (irq_out);
endmodule

// *** verif/meas_unit_model.sv ***
`timescale 1ns/1ps

module meas_unit_model (
  // clock and control
  input wire clk_in,
  input wire launch_in,
  input wire [1:0] nfreq_in,
  input wire [47:0] cnt_in,
  input wire [3:0] gap_in,
  // sample stream
  output reg valid_out,
  output reg [15:0] count_out,
  output reg [1:0] sensor_out,
  output reg [1:0] freq_out,
  output reg done_out
);
  integer s;
  integer f;

  // idle lines show the inverse of the last sample, never a stale copy
  task idle; begin
    valid_out <= 1'h0;
    count_out <= ~count_out;
    sensor_out <= ~sensor_out;
    freq_out <= ~freq_out;
  end endtask

  // one sample per sensor and frequency after each launch
  initial begin
    valid_out = 1'h0;
    done_out = 1'h0;
    count_out = 16'hffff;
    sensor_out = 2'h3;
    freq_out = 2'h3;
    forever begin
      @(posedge clk_in);
      if (launch_in === 1'h1) begin
        for (s = 0; s < 4; s = s + 1) begin
          for (f = 0; f < nfreq_in; f = f + 1) begin
            valid_out <= 1'h1;
            count_out <= cnt_in[f*16 +: 16];
            sensor_out <= s[1:0];
            freq_out <= f[1:0];
            @(posedge clk_in);
            if (gap_in != 4'h0) begin
              idle;
              repeat (gap_in) @(posedge clk_in);
            end
          end
        end
        if (gap_in == 4'h0)
          idle;
        done_out <= 1'h1;
        @(posedge clk_in);
        done_out <= 1'h0;
      end
    end
  end
endmodule

// *** verif/touch_measurement_correction_tb.sv ***
`timescale 1ns/1ps
`include "tmc_regs.vh"

module touch_measurement_correction_tb;
  reg clk_in;
  reg resetn_in;
  reg [7:0] addr_in;
  reg [31:0] wdata_in;
  reg wr_in;
  reg rd_in;
  reg [47:0] cnt;
  reg [3:0] gap;
  reg [31:0] v;
  wire [31:0] rdata_out;
  wire scan_launch_out;
  wire high_res_out;
  wire [1:0] freq_count_out;
  wire meas_valid_in;
  wire [`CW-1:0] meas_count_in;
  wire [1:0] meas_sensor_in;
  wire [1:0] meas_freq_in;
  wire meas_done_in;
  wire result_valid_out;
  wire judge_ready_out;
  wire irq_out;
  integer err_total;
  integer n_tests;

  // block under test and the measurement unit facing it
  touch_measurement_correction touch_measurement_correction_i (.clk_in(clk_in), .resetn_in(resetn_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .scan_launch_out(scan_launch_out), .high_res_out(high_res_out), .freq_count_out(freq_count_out),
    .meas_valid_in(meas_valid_in), .meas_count_in(meas_count_in), .meas_sensor_in(meas_sensor_in),
    .meas_freq_in(meas_freq_in), .meas_done_in(meas_done_in), .result_valid_out(result_valid_out),
    .judge_ready_out(judge_ready_out), .irq_out(irq_out));
  meas_unit_model meas_unit_model_i (.clk_in(clk_in), .launch_in(scan_launch_out),
    .nfreq_in(freq_count_out), .cnt_in(cnt), .gap_in(gap), .valid_out(meas_valid_in),
    .count_out(meas_count_in), .sensor_out(meas_sensor_in), .freq_out(meas_freq_in), .done_out(meas_done_in));

  // ********
  // helpers
  // ********
  // four-state compare so an unknown never matches
  task check(input [31:0] seen, input [31:0] exp); begin
    n_tests = n_tests + 1;
    if (seen !== exp) begin
      err_total = err_total + 1;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  end endtask

  // an idle edge after each strobe keeps one assignment per time step
  task reg_wr(input [7:0] a, input [31:0] d); begin
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'h1;
    @(posedge clk_in);
    wr_in <= 1'h0;
    @(posedge clk_in);
  end endtask

  task reg_rd(input [7:0] a, output [31:0] d); begin
    addr_in <= a;
    rd_in <= 1'h1;
    @(posedge clk_in);
    rd_in <= 1'h0;
    @(posedge clk_in);
    d = rdata_out;
  end endtask

  task res_chk(input [3:0] ch, input [31:0] e); begin
    reg_wr(`ADDR_RES_SEL, {28'h0, ch});
    reg_rd(`ADDR_RES_DATA, v);
    check(v, e);
  end endtask

  // setup plus tuning scan, polled to ready under a bound
  task do_init(input [1:0] ctrl, input [47:0] c); integer i; begin
    reg_wr(`ADDR_CTRL, {30'h0, ctrl});
    cnt <= c;
    reg_wr(`ADDR_CMD, 32'h1);
    v = 32'h0;
    for (i = 0; i < 200 && v[2:0] !== 3'h3; i = i + 1)
      reg_rd(`ADDR_STATUS, v);
    check(v[2:0], 3'h3);
    check(v[4], 1'h1);
  end endtask

  task run_scan(input [47:0] c, input [3:0] g); integer i; begin
    cnt <= c;
    gap <= g;
    reg_wr(`ADDR_CMD, 32'h2);
    for (i = 0; i < 300 && judge_ready_out !== 1'h1; i = i + 1)
      @(posedge clk_in);
    check(result_valid_out, 1'h1);
    repeat (3) @(posedge clk_in);
  end endtask

  // ********
  // scenarios
  // ********
  task t_reset; begin
    reg_rd(`ADDR_CAL, v);
    check(v, 32'h40);
    reg_rd(`ADDR_STATUS, v);
    check(v, 32'h0);
    reg_rd(8'h24, v);
    check(v, 32'h0);
    check(freq_count_out, 2'h1);
    $display("reset test done");
  end endtask

  task t_init; begin
    reg_wr(`ADDR_IRQ_MASK, 32'hf);
    do_init(2'h0, 48'h0500);
    reg_rd(`ADDR_IRQ_STAT, v);
    check(v[1:0], 2'h3);
    check(irq_out, 1'h1);
    reg_wr(`ADDR_IRQ_STAT, 32'hf);
    check(irq_out, 1'h0);
    reg_wr(`ADDR_RES_SEL, 32'h3);
    reg_rd(`ADDR_OFFSET, v);
    check(v, 32'h100);
    $display("init test done");
  end endtask

  // masked result event, then unmasked; slow then back-to-back samples
  task t_single; begin
    reg_wr(`ADDR_IRQ_MASK, 32'h0);
    run_scan(48'h1234, 4'h2);
    res_chk(4'h0, 32'h1214);
    res_chk(4'h9, 32'h1214);
    res_chk(4'h1, 32'h0);
    check(irq_out, 1'h0);
    reg_wr(`ADDR_IRQ_MASK, 32'h8);
    check(irq_out, 1'h1);
    run_scan(48'h12b4, 4'h0);
    res_chk(4'h0, 32'h1224);
    $display("single test done");
  end endtask

  task t_vmm; begin
    do_init(2'h1, 48'h0500_0500_0500);
    check(high_res_out, 1'h1);
    run_scan(48'h0700_0500_0900, 4'h1);
    res_chk(4'h0, 32'hf80);
    res_chk(4'h3, 32'hf80);
    $display("value majority test done");
  end endtask

  task t_jmm; begin
    do_init(2'h3, 48'h0500_0500_0500);
    run_scan(48'h0700_1500_0900, 4'h0);
    res_chk(4'h0, 32'h800);
    res_chk(4'h1, 32'h14e0);
    res_chk(4'hb, 32'h600);
    res_chk(4'hc, 32'h0);
    $display("judgement majority test done");
  end endtask

  task final_report; begin
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  end endtask

  // 100 ns clock
  initial begin
    clk_in = 1'h0;
    forever #50 clk_in = ~clk_in;
  end

  // whole run is a few hundred cycles; cut off well beyond
  initial begin
    #2000000;
    err_total = err_total + 1;
    final_report;
  end

  // reset, then the scenarios
  initial begin
    err_total = 0;
    n_tests = 0;
    resetn_in = 1'h0;
    addr_in = 8'h00;
    wdata_in = 32'h0;
    wr_in = 1'h0;
    rd_in = 1'h0;
    cnt = 48'h0;
    gap = 4'h0;
    repeat (6) @(posedge clk_in);
    resetn_in <= 1'h1;
    @(posedge clk_in);
    t_reset;
    t_init;
    t_single;
    t_vmm;
    t_jmm;
    final_report;
  end
endmodule

bind touch_measurement_correction touch_measurement_correction_monitor touch_measurement_correction_monitor_i (
  .clk_in(clk_in), .resetn_in(resetn_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
  .rd_in(rd_in), .rdata_out(rdata_out), .scan_launch_out(scan_launch_out), .high_res_out(high_res_out),
  .freq_count_out(freq_count_out), .meas_done_in(meas_done_in), .result_valid_out(result_valid_out),
  .judge_ready_out(judge_ready_out), .irq_out(irq_out));
